// ### pkg/gpafm_pkg.sv
package gpafm_pkg;

    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int PIN_COUNT      = 54;
    localparam int LOW_PINS       = 32;
    localparam int HIGH_PINS      = 22;
    localparam int CHOICE_PINS    = 9;
    localparam int CHOICE_W       = 2;
    localparam int CHOICE_BITS    = CHOICE_PINS * CHOICE_W;
    localparam int DATA_W         = 32;
    localparam int ADDR_W         = 12;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] FUNC_LOW_ADDR  = 12'hA90;
    localparam logic [ADDR_W-1:0] FUNC_HIGH_ADDR = 12'hA94;
    localparam logic [ADDR_W-1:0] CHOICE_ADDR    = 12'hA98;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [LOW_PINS-1:0]    FUNC_LOW_RST  = 32'h0000_0000;
    localparam logic [HIGH_PINS-1:0]   FUNC_HIGH_RST = 22'h00_0000;
    localparam logic [CHOICE_BITS-1:0] CHOICE_RST    = 18'h0_0000;

    // ------------------------------------------------------------
    // Alternate choice encoding
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        GPAFM_PATH_ZERO = 2'h0,
        GPAFM_PATH_ONE  = 2'h1,
        GPAFM_PATH_RSV2 = 2'h2,
        GPAFM_PATH_RSV3 = 2'h3
    } gpafm_choice_e;

endpackage

// ### logic/gpafm_pin_route.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Per-pin routing of output, enable and input between paths
// ------------------------------------------------------------
module gpafm_pin_route #(
    parameter bit HAS_CHOICE = 1'b1
) (
    input  wire logic       funcSel,
    input  wire logic [1:0] choice,
    input  wire logic       gpOut,
    input  wire logic       gpOe,
    input  wire logic       alt0Out,
    input  wire logic       alt0Oe,
    input  wire logic       alt1Out,
    input  wire logic       alt1Oe,
    input  wire logic       padIn,
    output logic            padOut,
    output logic            padOe,
    output logic            gpIn,
    output logic            alt0In,
    output logic            alt1In
);

    // Choice matters only in alternate mode; reserved codes drive nothing
    always_comb begin
        padOut = gpOut;
        padOe  = gpOe;
        alt0In = 1'b0;
        alt1In = 1'b0;
        if (funcSel) begin
            padOut = 1'b0;
            padOe  = 1'b0;
            if (!HAS_CHOICE || choice == gpafm_pkg::GPAFM_PATH_ZERO) begin
                padOut = alt0Out;
                padOe  = alt0Oe;
                alt0In = padIn;
            end else if (choice == gpafm_pkg::GPAFM_PATH_ONE) begin
                padOut = alt1Out;
                padOe  = alt1Oe;
                alt1In = padIn;
            end
        end
    end

    // General purpose input sees the pin only in general purpose mode
    assign gpIn = funcSel ? 1'b0 : padIn;

endmodule // gpafm_pin_route

// ### logic/gpafm_mux.sv
`timescale 1ns/1ps
module gpafm_mux #(
    parameter int PINS = gpafm_pkg::PIN_COUNT
) (
    input  wire logic                           ref_clk,
    input  wire logic                           rst_n,
    input  wire logic                           psel,
    input  wire logic                           penable,
    input  wire logic                           pwrite,
    input  wire logic [gpafm_pkg::ADDR_W-1:0]   paddr,
    input  wire logic [gpafm_pkg::DATA_W-1:0]   pwdata,
    input  wire logic [3:0]                     pstrb,
    output logic      [gpafm_pkg::DATA_W-1:0]   prdata,
    output logic                                pready,
    output logic                                pslverr,
    input  wire logic [PINS-1:0]                gpOut,
    input  wire logic [PINS-1:0]                gpOe,
    output logic      [PINS-1:0]                gpIn,
    input  wire logic [PINS-1:0]                altZeroOut,
    input  wire logic [PINS-1:0]                altZeroOe,
    output logic      [PINS-1:0]                altZeroIn,
    input  wire logic [PINS-1:0]                altOneOut,
    input  wire logic [PINS-1:0]                altOneOe,
    output logic      [PINS-1:0]                altOneIn,
    input  wire logic [PINS-1:0]                padIn,
    output logic      [PINS-1:0]                padOut,
    output logic      [PINS-1:0]                padOe,
    output logic      [PINS-1:0]                pinFunctionBits
);

    localparam int LP = gpafm_pkg::LOW_PINS;
    localparam int HP = gpafm_pkg::HIGH_PINS;
    localparam int CB = gpafm_pkg::CHOICE_BITS;
    localparam int CP = gpafm_pkg::CHOICE_PINS;
    localparam int CW = gpafm_pkg::CHOICE_W;

    logic [LP-1:0]  funcLow_ff;
    logic [HP-1:0]  funcHigh_ff;
    logic [CB-1:0]  choice_ff;
    logic [PINS-1:0] padInMeta_ff;
    logic [PINS-1:0] padInSync_ff;
    logic           wrEn;
    logic           hitLow;
    logic           hitHigh;
    logic           hitChoice;
    logic [31:0]    byteMask;
    logic [31:0]    nxt_prdata;

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------

    // Decode; zero wait states, unmapped accesses flag an error
    assign hitLow    = (paddr == gpafm_pkg::FUNC_LOW_ADDR);
    assign hitHigh   = (paddr == gpafm_pkg::FUNC_HIGH_ADDR);
    assign hitChoice = (paddr == gpafm_pkg::CHOICE_ADDR);
    assign wrEn      = psel && penable && pwrite;
    assign pready    = 1'b1;
    assign pslverr   = psel && penable && !(hitLow || hitHigh || hitChoice);

    // Byte lanes expanded from strobes
    generate
        for (genvar b = 0; b < 4; b++) begin : g_lane
            assign byteMask[8*b +: 8] = {8{pstrb[b]}};
        end
    endgenerate

    // Function registers, cleared at reset only
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            funcLow_ff  <= gpafm_pkg::FUNC_LOW_RST;
            funcHigh_ff <= gpafm_pkg::FUNC_HIGH_RST;
        end else if (wrEn) begin
            if (hitLow) begin
                funcLow_ff <= (funcLow_ff & ~byteMask) | (pwdata & byteMask);
            end
            if (hitHigh) begin
                funcHigh_ff <= (funcHigh_ff & ~byteMask[HP-1:0]) | (pwdata[HP-1:0] & byteMask[HP-1:0]);
            end
        end
    end

    // Alternate choice register
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            choice_ff <= gpafm_pkg::CHOICE_RST;
        end else if (wrEn && hitChoice) begin
            choice_ff <= (choice_ff & ~byteMask[CB-1:0]) | (pwdata[CB-1:0] & byteMask[CB-1:0]);
        end
    end

    // Read data, reserved bits zero
    always_comb begin
        nxt_prdata = '0;
        if (hitLow) begin
            nxt_prdata = funcLow_ff;
        end else if (hitHigh) begin
            nxt_prdata[HP-1:0] = funcHigh_ff;
        end else if (hitChoice) begin
            nxt_prdata[CB-1:0] = choice_ff;
        end
    end
    assign prdata = (psel && !pwrite) ? nxt_prdata : '0;

    // ------------------------------------------------------------
    // Pin input synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            padInMeta_ff <= '0;
            padInSync_ff <= '0;
        end else begin
            padInMeta_ff <= padIn;
            padInSync_ff <= padInMeta_ff;
        end
    end

    // ------------------------------------------------------------
    // Per-pin routing
    // ------------------------------------------------------------
    assign pinFunctionBits = {funcHigh_ff, funcLow_ff};

    generate
        for (genvar p = 0; p < PINS; p++) begin : g_pin
            localparam bit HASC = (p < CP);
            logic [1:0] pinChoice;
            if (HASC) begin : g_c
                assign pinChoice = choice_ff[CW*p +: CW];
            end else begin : g_nc
                assign pinChoice = gpafm_pkg::GPAFM_PATH_ZERO;
            end
            gpafm_pin_route #(
                .HAS_CHOICE (HASC)
            ) u_route (
                .funcSel (pinFunctionBits[p]),
                .choice  (pinChoice),
                .gpOut   (gpOut[p]),
                .gpOe    (gpOe[p]),
                .alt0Out (altZeroOut[p]),
                .alt0Oe  (altZeroOe[p]),
                .alt1Out (altOneOut[p]),
                .alt1Oe  (altOneOe[p]),
                .padIn   (padInSync_ff[p]),
                .padOut  (padOut[p]),
                .padOe   (padOe[p]),
                .gpIn    (gpIn[p]),
                .alt0In  (altZeroIn[p]),
                .alt1In  (altOneIn[p])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    AST_GP_PATH: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !pinFunctionBits[20] |-> (padOut[20] == gpOut[20] && padOe[20] == gpOe[20]))
        else $error("general purpose pin not routed to gp path");
    AST_ALT_ZERO: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (pinFunctionBits[0] && choice_ff[1:0] == 2'h0) |-> padOut[0] == altZeroOut[0])
        else $error("pin 0 not on path zero");
    AST_ALT_ONE_P8: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (pinFunctionBits[8] && choice_ff[17:16] == 2'h1) |-> padOe[8] == altOneOe[8])
        else $error("pin 8 not on path one");
    AST_RSV_CODE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (pinFunctionBits[1] && choice_ff[3:2] == 2'h3) |-> !padOe[1])
        else $error("reserved choice drives pin");
    AST_CHOICE_GATED: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !pinFunctionBits[3] |-> (altOneIn[3] == 1'b0 && altZeroIn[3] == 1'b0))
        else $error("choice routes a gp pin");
    AST_LOW_WRITE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (wrEn && hitLow && pstrb == 4'hF) |=> funcLow_ff == $past(pwdata))
        else $error("low function write lost");
    AST_HIGH_RSV: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (psel && !pwrite && hitHigh) |-> prdata[31:22] == 10'h000)
        else $error("high reserved bits nonzero");
    AST_CHOICE_RSV: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (psel && !pwrite && hitChoice) |-> prdata[31:18] == 14'h0000)
        else $error("choice reserved bits nonzero");
    AST_RESET_GP: assert property (@(posedge ref_clk)
        $rose(rst_n) |-> (pinFunctionBits == '0 && choice_ff == '0))
        else $error("fields not zero after reset");

endmodule // gpafm_mux

// ### test/gpafm_pin_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Pad with an outside driver where the block lets go
// ------------------------------------------------------------
module gpafm_pin_model (
    input  wire logic [53:0] padOut,
    input  wire logic [53:0] padOe,
    input  wire logic [53:0] extLevel,
    output logic      [53:0] padIn
);
    // Released pins show the outside level, driven pins their own
    assign padIn = (padOe & padOut) | (~padOe & extLevel);
endmodule // gpafm_pin_model

// ### test/testbench.sv
`timescale 1ns/1ps
`define CHK(a, e, m) begin checks_done++; if ((a) !== (e)) begin miscompares++; $display("mismatch %0t %s", $time, m); end end
module testbench;
    logic        ref_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [3:0]  pstrb = 4'hF;
    logic [53:0] gpOut = '0, gpOe = '0, altZeroOut = '0, altZeroOe = '0, altOneOut = '0, altOneOe = '0;
    logic [53:0] extLevel = '0, gpIn, altZeroIn, altOneIn, padIn, padOut, padOe, pinFunctionBits;
    logic [31:0] expQ[$];
    int          miscompares = 0, checks_done = 0;

    // ------------------------------------------------------------
    // Design, pad model and clock
    // ------------------------------------------------------------
    gpafm_mux dut (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .gpOut(gpOut), .gpOe(gpOe), .gpIn(gpIn), .altZeroOut(altZeroOut), .altZeroOe(altZeroOe),
        .altZeroIn(altZeroIn), .altOneOut(altOneOut), .altOneOe(altOneOe), .altOneIn(altOneIn),
        .padIn(padIn), .padOut(padOut), .padOe(padOe), .pinFunctionBits(pinFunctionBits));
    gpafm_pin_model pad (.padOut(padOut), .padOe(padOe), .extLevel(extLevel), .padIn(padIn));
    always #10 ref_clk = ~ref_clk;

    // Closing report
    task automatic end_of_test();
        $display("checks %0d, mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // One APB transfer; reads note their expected data
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [31:0] e);
        int n;
        n = 0;
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        if (!wr) expQ.push_back(e);
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin @(posedge ref_clk); n++; end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin miscompares++; end_of_test(); end
        psel <= 1'b0; penable <= 1'b0;
        @(posedge ref_clk); // Idle edge so the next setup never re-raises psel in this step
    endtask

    // Monitor: read data against the oldest note, error flag on every access
    always @(posedge ref_clk) begin
        if (psel && penable && pready === 1'b1) begin
            `CHK(pslverr, !(paddr inside {gpafm_pkg::FUNC_LOW_ADDR, gpafm_pkg::FUNC_HIGH_ADDR, gpafm_pkg::CHOICE_ADDR}), "err flag")
            if (!pwrite) `CHK(prdata, expQ.pop_front(), "read data")
        end
    end

    // Program the three registers, stir the paths, compare routing and readback
    task automatic route_check(input logic [31:0] lo, input logic [31:0] hi, input logic [31:0] ch);
        logic [53:0] f, eo, ee, s0, s1, lvl;
        logic [63:0] r[7];
        logic [1:0]  c;
        apb(1'b1, gpafm_pkg::FUNC_LOW_ADDR, lo, 32'h0);
        apb(1'b1, gpafm_pkg::FUNC_HIGH_ADDR, hi, 32'h0);
        apb(1'b1, gpafm_pkg::CHOICE_ADDR, ch, 32'h0);
        foreach (r[i]) r[i] = {$urandom, $urandom};
        gpOut <= r[0][53:0]; gpOe <= r[1][53:0]; altZeroOut <= r[2][53:0]; altZeroOe <= r[3][53:0];
        altOneOut <= r[4][53:0]; altOneOe <= r[5][53:0]; extLevel <= r[6][53:0];
        repeat (4) @(posedge ref_clk);
        f = {hi[21:0], lo};
        for (int p = 0; p < 54; p++) begin
            c = (p < 9) ? ch[2*p +: 2] : 2'h0;
            s0[p] = f[p] && c == 2'h0;
            s1[p] = f[p] && c == 2'h1;
            eo[p] = !f[p] ? gpOut[p] : s0[p] ? altZeroOut[p] : altOneOut[p];
            ee[p] = !f[p] ? gpOe[p] : s0[p] ? altZeroOe[p] : s1[p] && altOneOe[p];
        end
        lvl = (ee & eo) | (~ee & extLevel); // Expected pin level from the expected drive
        `CHK(pinFunctionBits, f, "function bits")
        `CHK(padOe, ee, "pad enable")
        `CHK(padOut & ee, eo & ee, "pad drive")
        `CHK(gpIn, lvl & ~f, "gp input")
        `CHK(altZeroIn, lvl & s0, "path zero input")
        `CHK(altOneIn, lvl & s1, "path one input")
        apb(1'b0, gpafm_pkg::FUNC_LOW_ADDR, 32'h0, lo);
        apb(1'b0, gpafm_pkg::FUNC_HIGH_ADDR, 32'h0, {10'h000, hi[21:0]});
        apb(1'b0, gpafm_pkg::CHOICE_ADDR, 32'h0, {14'h0000, ch[17:0]});
    endtask

    // Reset, then read every register back as zero
    task automatic reset_check();
        rst_n <= 1'b0;
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        apb(1'b0, gpafm_pkg::FUNC_LOW_ADDR, 32'h0, 32'h0);
        apb(1'b0, gpafm_pkg::FUNC_HIGH_ADDR, 32'h0, 32'h0);
        apb(1'b0, gpafm_pkg::CHOICE_ADDR, 32'h0, 32'h0);
        `CHK(padOe, gpOe, "reset enable")
        `CHK(padOut, gpOut, "reset drive")
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(75189));
        reset_check();
        apb(1'b0, 12'hA9C, 32'h0, 32'h0);
        apb(1'b1, 12'hA9C, 32'hFFFF_FFFF, 32'h0);
        $display("reset and unmapped test done");
        route_check(32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF);
        for (int k = 0; k < 4; k++) route_check($urandom | 32'h1FF, $urandom, {16{k[1:0]}});
        route_check(32'h0, 32'h0, $urandom);
        $display("routing test done");
        reset_check();
        $display("second reset test done");
        end_of_test();
    end
endmodule // testbench
